// ==== logic/g7ci_pkg.sv ====
// constants shared by the co-directional line interface
package g7ci_pkg;

  // ----------------------------------------------------------------
  // line rate and clock
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned LINE_RATE_BPS = 64_000;
  localparam int unsigned UNITS_PER_BIT = 4;
  // each unit interval rounds down to whole cycles
  localparam int unsigned UNIT_CYCLES   = CLK_HZ / (LINE_RATE_BPS * UNITS_PER_BIT);
  localparam int unsigned DIV_W         = $clog2(UNIT_CYCLES);

  // ----------------------------------------------------------------
  // octet framing
  // ----------------------------------------------------------------
  localparam int unsigned OCTET_W      = 8;
  localparam logic [2:0]  LSB_INDEX    = 3'h7;
  localparam logic [7:0]  IDLE_OCTET   = 8'hFF;
  localparam int unsigned FIFO_DEPTH   = 8;

  // ----------------------------------------------------------------
  // reset values and strap capture
  // ----------------------------------------------------------------
  localparam logic [1:0]  SETTLE_CYCLES = 2'h3;
  localparam logic [1:0]  UNIT_RESET    = 2'h0;
  localparam logic [1:0]  UNIT_LAST     = 2'h3;

  typedef enum logic [1:0] {
    G7CI_LOOP_TIMING,
    G7CI_INTERNAL_TIMING,
    G7CI_MIN_REMOTE_LOOP,
    G7CI_DUAL_LOOP
  } g7ci_mode_e;

endpackage

// ==== logic/g7ci_fifo.sv ====
// flip-flop fifo with valid and ready on both sides
module g7ci_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             reset_n_i,
  // fill side
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  // drain side
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (1 << PTR_W) != DEPTH || WIDTH < 1) begin : g_bad
      $error("g7ci_fifo: depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   count;
  wire              do_write = in_valid_i & in_ready_o;
  wire              do_read  = out_valid_o & out_ready_i;

  assign in_ready_o  = (count != PTR_W'(0) + (PTR_W+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  always_ff @(posedge clk_sys_i) begin
    if (do_write) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= wr_ptr + PTR_W'(do_write);
      rd_ptr <= rd_ptr + PTR_W'(do_read);
      count  <= count + (PTR_W+1)'(do_write) - (PTR_W+1)'(do_read);
    end
  end

endmodule

// ==== logic/g7ci_top.sv ====
// co-directional 64 kbps line interface with timing and loopback modes

// ----------------------------------------------------------------
// module
// ----------------------------------------------------------------
module g7ci_top #(
  parameter int unsigned FIFO_DEPTH = g7ci_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  // static switches
  input  wire logic       octet_timing_switch_i,
  input  wire logic       timing_mode_switch_a_i,
  input  wire logic       timing_mode_switch_b_i,
  // line receive pins and recovered unit clock
  input  wire logic       line_rx_pos_i,
  input  wire logic       line_rx_neg_i,
  input  wire logic       line_unit_clk_i,
  // line transmit pins
  output logic            line_tx_pos_o,
  output logic            line_tx_neg_o,
  // octets from the internal receiver toward the line
  input  wire logic [7:0] dm_rx_data_i,
  input  wire logic       dm_rx_valid_i,
  output logic            dm_rx_ready_o,
  // octets toward the internal transmitter
  output logic [7:0]      dm_tx_data_o,
  output logic            dm_tx_valid_o,
  // captured configuration
  output logic [1:0]      mode_o,
  output logic            octet_timing_o,
  output logic            config_valid_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic       clk_s3;

  always_ff @(posedge clk_sys_i) begin
    pin_s1 <= {octet_timing_switch_i, timing_mode_switch_a_i, timing_mode_switch_b_i,
               line_rx_pos_i, line_rx_neg_i, line_unit_clk_i};
    pin_s2 <= pin_s1;
    clk_s3 <= pin_s2[0];
  end

  wire rx_pos  = pin_s2[2];
  wire rx_neg  = pin_s2[1];
  wire rx_tick = pin_s2[0] & ~clk_s3;

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  logic       cfg_loaded;
  logic [1:0] settle;
  logic       octet_on;
  g7ci_pkg::g7ci_mode_e mode;

  // switches are not re-read once loaded
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      cfg_loaded <= 1'b0;
      settle     <= 2'h0;
      octet_on   <= 1'b0;
      mode       <= g7ci_pkg::G7CI_LOOP_TIMING;
    end else if (!cfg_loaded) begin
      settle <= settle + 2'h1;
      if (settle == g7ci_pkg::SETTLE_CYCLES) begin
        cfg_loaded <= 1'b1;
        octet_on   <= pin_s2[5];
        case ({pin_s2[3], pin_s2[4]})
          2'b00:   mode <= g7ci_pkg::G7CI_LOOP_TIMING;
          2'b01:   mode <= g7ci_pkg::G7CI_INTERNAL_TIMING;
          2'b10:   mode <= g7ci_pkg::G7CI_MIN_REMOTE_LOOP;
          2'b11:   mode <= g7ci_pkg::G7CI_DUAL_LOOP;
          default: mode <= g7ci_pkg::G7CI_LOOP_TIMING;
        endcase
      end
    end
  end

  wire is_internal = (mode == g7ci_pkg::G7CI_INTERNAL_TIMING);
  wire is_minrl    = (mode == g7ci_pkg::G7CI_MIN_REMOTE_LOOP);
  wire is_dual     = (mode == g7ci_pkg::G7CI_DUAL_LOOP);

  assign mode_o         = mode;
  assign octet_timing_o = octet_on;
  assign config_valid_o = cfg_loaded;

  // ----------------------------------------------------------------
  // internal unit clock
  // ----------------------------------------------------------------
  logic [g7ci_pkg::DIV_W-1:0] div_cnt;
  wire div_tick = (div_cnt == g7ci_pkg::DIV_W'(g7ci_pkg::UNIT_CYCLES - 1));

  // fixed divider, no rate setting reaches it
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || div_tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + g7ci_pkg::DIV_W'(1);
    end
  end

  wire tx_tick = is_internal ? div_tick : rx_tick;

  // ----------------------------------------------------------------
  // line decoder
  // ----------------------------------------------------------------
  logic [1:0] rx_unit;
  logic       rx_pol;
  logic       rx_viol;
  logic       rx_bit;
  logic [7:0] rx_shift;
  logic [2:0] rx_cnt;
  logic [7:0] rx_octet;
  logic       rx_octet_valid;

  wire rx_mark  = rx_pos | rx_neg;
  wire rx_bit_d = rx_bit;
  wire rx_end   = rx_tick & (rx_unit == g7ci_pkg::UNIT_LAST);
  wire rx_lsb   = octet_on ? rx_viol : (rx_cnt == g7ci_pkg::LSB_INDEX);
  wire [7:0] next_rx_shift = {rx_shift[6:0], rx_bit_d};

  // a block always opens with a mark; hold unit 0 until one is seen
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || !cfg_loaded) begin
      rx_unit        <= g7ci_pkg::UNIT_RESET;
      rx_pol         <= 1'b0;
      rx_viol        <= 1'b0;
      rx_bit         <= 1'b0;
      rx_shift       <= 8'h00;
      rx_cnt         <= 3'h0;
      rx_octet       <= 8'h00;
      rx_octet_valid <= 1'b0;
    end else begin
      rx_octet_valid <= 1'b0;
      if (rx_tick) begin
        if (rx_unit == g7ci_pkg::UNIT_RESET) begin
          if (rx_mark) begin
            rx_unit <= 2'h1;
            rx_pol  <= rx_pos;
            rx_viol <= (rx_pos == rx_pol);
          end
        end else begin
          rx_unit <= rx_unit + 2'h1;
        end
        if (rx_unit == 2'h1) begin
          rx_bit <= rx_mark;
        end
      end
      if (rx_end) begin
        rx_shift <= next_rx_shift;
        if (rx_lsb) begin
          rx_cnt         <= 3'h0;
          rx_octet       <= next_rx_shift;
          rx_octet_valid <= 1'b1;
        end else begin
          rx_cnt <= rx_cnt + 3'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit fifo
  // ----------------------------------------------------------------
  logic [7:0] fifo_data;
  logic       fifo_valid;
  logic       tx_load;
  wire        fifo_ready = is_minrl | is_dual | tx_load;

  g7ci_fifo #(
    .WIDTH (g7ci_pkg::OCTET_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .reset_n_i   (reset_n_i),
    .in_data_i   (dm_rx_data_i),
    .in_valid_i  (dm_rx_valid_i),
    .in_ready_o  (dm_rx_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_ready)
  );

  // ----------------------------------------------------------------
  // internal side output
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      dm_tx_data_o  <= 8'h00;
      dm_tx_valid_o <= 1'b0;
    end else if (is_dual) begin
      dm_tx_data_o  <= fifo_data;
      dm_tx_valid_o <= fifo_valid;
    end else begin
      dm_tx_data_o  <= rx_octet;
      dm_tx_valid_o <= rx_octet_valid;
    end
  end

  // ----------------------------------------------------------------
  // line encoder
  // ----------------------------------------------------------------
  logic [1:0] tx_unit;
  logic [2:0] tx_idx;
  logic [7:0] tx_octet;
  logic       tx_pol;
  logic       enc_pos;
  logic       enc_neg;
  logic [7:0] dual_octet;

  wire       tx_bit     = tx_octet[3'h7 - tx_idx];
  wire       tx_mark    = (tx_unit == 2'h0) | ((tx_unit == 2'h1) & tx_bit) | ((tx_unit == 2'h2) & ~tx_bit);
  wire [2:0] next_idx   = tx_idx + 3'h1;
  wire       next_viol  = octet_on & (next_idx == g7ci_pkg::LSB_INDEX);
  wire       tx_end     = tx_tick & (tx_unit == g7ci_pkg::UNIT_LAST);
  wire [7:0] next_octet = is_dual ? dual_octet : (fifo_valid ? fifo_data : g7ci_pkg::IDLE_OCTET);

  assign tx_load = tx_end & (tx_idx == g7ci_pkg::LSB_INDEX) & ~is_dual;

  // dual loopback re-encodes decoded octets on the recovered timing
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      dual_octet <= g7ci_pkg::IDLE_OCTET;
    end else if (rx_octet_valid) begin
      dual_octet <= rx_octet;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || !cfg_loaded) begin
      tx_unit  <= g7ci_pkg::UNIT_RESET;
      tx_idx   <= 3'h0;
      tx_octet <= g7ci_pkg::IDLE_OCTET;
      tx_pol   <= 1'b0;
      enc_pos  <= 1'b0;
      enc_neg  <= 1'b0;
    end else if (tx_tick) begin
      enc_pos <= tx_mark & tx_pol;
      enc_neg <= tx_mark & ~tx_pol;
      tx_unit <= tx_unit + 2'h1;
      if (tx_unit == g7ci_pkg::UNIT_LAST) begin
        tx_idx <= next_idx;
        if (tx_idx == g7ci_pkg::LSB_INDEX) begin
          tx_octet <= next_octet;
        end
        // violation repeats the previous block polarity
        tx_pol <= next_viol ? tx_pol : ~tx_pol;
      end
    end
  end

  // ----------------------------------------------------------------
  // line output select
  // ----------------------------------------------------------------
  // the synchroniser pair is the stabilising latch; timing follows the line
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      line_tx_pos_o <= 1'b0;
      line_tx_neg_o <= 1'b0;
    end else if (is_minrl) begin
      line_tx_pos_o <= rx_pos;
      line_tx_neg_o <= rx_neg;
    end else begin
      line_tx_pos_o <= enc_pos;
      line_tx_neg_o <= enc_neg;
    end
  end

endmodule

// ==== bench/g7ci_top_props.sv ====
// checker on the ports of the line interface top
module g7ci_top_props (
  // clock, reset, switches
  input wire logic       clk_sys_i,
  input wire logic       reset_n_i,
  input wire logic       octet_timing_switch_i,
  input wire logic       timing_mode_switch_a_i,
  input wire logic       timing_mode_switch_b_i,
  // line side
  input wire logic       line_rx_pos_i,
  input wire logic       line_rx_neg_i,
  input wire logic       line_unit_clk_i,
  input wire logic       line_tx_pos_o,
  input wire logic       line_tx_neg_o,
  // internal side and config
  input wire logic [7:0] dm_rx_data_i,
  input wire logic       dm_rx_valid_i,
  input wire logic       dm_rx_ready_o,
  input wire logic [7:0] dm_tx_data_o,
  input wire logic       dm_tx_valid_o,
  input wire logic [1:0] mode_o,
  input wire logic       octet_timing_o,
  input wire logic       config_valid_o
);
  logic [1:0]  prev_tx;
  logic [15:0] gap;
  logic        seen;
  logic        unit_was;
  logic [7:0]  since_rise;
  wire  [1:0]  cur_tx    = {line_tx_pos_o, line_tx_neg_o};
  wire         tx_moved  = cur_tx != prev_tx;
  wire         unit_rise = line_unit_clk_i & ~unit_was;
  // saturating so a stopped line clock never wraps into a false match
  always_ff @(posedge clk_sys_i) begin
    prev_tx <= cur_tx;
    unit_was <= line_unit_clk_i;
    gap <= tx_moved ? 16'h0001 : gap + 16'h0001;
    seen <= config_valid_o & (seen | tx_moved);
    since_rise <= unit_rise ? 8'h00 : (since_rise == 8'hff ? since_rise : since_rise + 8'h01);
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_reset_quiet: assert property ($rose(reset_n_i) |-> !config_valid_o && mode_o == 2'h0 && dm_rx_ready_o)
    else $error("outputs not idle after reset");
  a_config_time: assert property ($rose(reset_n_i) |-> !config_valid_o [*2] ##[1:4] config_valid_o)
    else $error("configuration not captured in time");
  a_config_hold: assert property (config_valid_o |=> config_valid_o && $stable(mode_o) && $stable(octet_timing_o))
    else $error("configuration changed while running");
  a_mode_map: assert property ($rose(config_valid_o) |->
    mode_o == {timing_mode_switch_b_i, timing_mode_switch_a_i} && octet_timing_o == octet_timing_switch_i)
    else $error("captured mode does not match switches");
  a_unit_spacing: assert property (mode_o == 2'h1 && seen && tx_moved |-> gap % g7ci_pkg::UNIT_CYCLES == 0)
    else $error("internal unit spacing wrong");
  a_loop_tick: assert property (config_valid_o && mode_o[0] == mode_o[1] && tx_moved |-> since_rise <= 8'h07)
    else $error("line output moved without line clock");
  a_remote_echo: assert property (mode_o == 2'h2 && config_valid_o && $past(config_valid_o, 3) |->
    cur_tx == {$past(line_rx_pos_i, 3), $past(line_rx_neg_i, 3)})
    else $error("remote loopback echo wrong");
  a_remote_drain: assert property (config_valid_o && mode_o == 2'h2 |-> dm_rx_ready_o)
    else $error("internal data not discarded");
  a_dual_pass: assert property (config_valid_o && mode_o == 2'h3 && dm_rx_valid_i && dm_rx_ready_o
    |-> ##[1:3] dm_tx_valid_o)
    else $error("dual loopback octet not returned");
endmodule

bind g7ci_top g7ci_top_props g7ci_top_props_i (.clk_sys_i, .reset_n_i, .octet_timing_switch_i,
  .timing_mode_switch_a_i, .timing_mode_switch_b_i, .line_rx_pos_i, .line_rx_neg_i, .line_unit_clk_i,
  .line_tx_pos_o, .line_tx_neg_o, .dm_rx_data_i, .dm_rx_valid_i, .dm_rx_ready_o, .dm_tx_data_o,
  .dm_tx_valid_o, .mode_o, .octet_timing_o, .config_valid_o);

// ==== bench/g7ci_line_peer.sv ====
// far end of the line: sends a fixed octet with its own unit clock
module g7ci_line_peer (
  input  wire logic run_i,
  output logic      unit_clk_o,
  output logic      pos_o,
  output logic      neg_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] PEER_OCTET = 8'ha5;
  int   u;
  logic pol;
  logic mark;
  // clock stands still while stopped; offset keeps edges off the system clock
  initial begin
    unit_clk_o = 1'b0;
    pos_o = 1'b0;
    neg_o = 1'b0;
    u = 0;
    pol = 1'b0;
    #3;
    forever begin
      if (run_i) begin
        mark = (u % 4 == 0) || (u % 4 == (PEER_OCTET[7 - u / 4] ? 1 : 2));
        pos_o = mark & pol;
        neg_o = mark & ~pol;
        #40 unit_clk_o = 1'b1;
        #40 unit_clk_o = 1'b0;
        u = (u + 1) % 32;
        // bit 7 keeps the previous polarity: octet timing violation
        if (u % 4 == 0 && u != 28) begin
          pol = ~pol;
        end
      end else begin
        pos_o = 1'b0;
        neg_o = 1'b0;
        // every run opens on bit 0 with a positive mark, so no false violation
        u = 0;
        pol = 1'b1;
        #8;
      end
    end
  end
endmodule

// ==== bench/g7ci_top_tb.sv ====
// self-checking bench for the line interface top
module g7ci_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys_i, reset_n_i, octet_timing_switch_i, timing_mode_switch_a_i, timing_mode_switch_b_i;
  logic       line_rx_pos_i, line_rx_neg_i, line_unit_clk_i, line_tx_pos_o, line_tx_neg_o;
  logic       dm_rx_valid_i, dm_rx_ready_o, dm_tx_valid_o, octet_timing_o, config_valid_o, peer_run;
  logic [7:0] dm_rx_data_i, dm_tx_data_o;
  logic [1:0] mode_o;
  int         miscompares, checked;
  g7ci_top g7ci_top_i (.clk_sys_i, .reset_n_i, .octet_timing_switch_i, .timing_mode_switch_a_i,
    .timing_mode_switch_b_i, .line_rx_pos_i, .line_rx_neg_i, .line_unit_clk_i, .line_tx_pos_o,
    .line_tx_neg_o, .dm_rx_data_i, .dm_rx_valid_i, .dm_rx_ready_o, .dm_tx_data_o, .dm_tx_valid_o,
    .mode_o, .octet_timing_o, .config_valid_o);
  g7ci_line_peer g7ci_line_peer_i (.run_i(peer_run), .unit_clk_o(line_unit_clk_i),
    .pos_o(line_rx_pos_i), .neg_o(line_rx_neg_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // reset, then prove the straps are ignored once captured
  task automatic start(input logic [1:0] m, input logic oct);
    @(negedge clk_sys_i);
    reset_n_i = 1'b0;
    peer_run = 1'b0;
    {timing_mode_switch_b_i, timing_mode_switch_a_i, octet_timing_switch_i} = {m, oct};
    repeat (16) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    chk("config_valid", 16'(config_valid_o), 16'h0001);
    chk("mode", 16'(mode_o), 16'(m));
    chk("octet_timing", 16'(octet_timing_o), 16'(oct));
    {timing_mode_switch_b_i, timing_mode_switch_a_i, octet_timing_switch_i} = ~{m, oct};
    repeat (8) @(negedge clk_sys_i);
    chk("mode held", 16'({octet_timing_o, mode_o}), 16'({oct, m}));
  endtask
  task automatic count_moves(input int n, output int c, output logic [8:0] d);
    logic [1:0] last;
    c = 0;
    d = 9'h000;
    last = {line_tx_pos_o, line_tx_neg_o};
    repeat (n) begin
      @(negedge clk_sys_i);
      c += int'({line_tx_pos_o, line_tx_neg_o} != last);
      last = {line_tx_pos_o, line_tx_neg_o};
      // keep the last octet handed to the internal side
      if (dm_tx_valid_o === 1'b1) begin
        d = {1'b1, dm_tx_data_o};
      end
    end
  endtask
  // fill the fifo until refused, then read polarity of nine line bits
  task automatic test_internal(input logic oct);
    int acc;
    int viol;
    logic prev;
    start(2'h1, oct);
    acc = 0;
    viol = 0;
    dm_rx_valid_i = 1'b1;
    for (int i = 0; i < 10; i++) begin
      dm_rx_data_i = 8'(i);
      acc += int'(dm_rx_ready_o);
      @(negedge clk_sys_i);
    end
    dm_rx_valid_i = 1'b0;
    chk("accepted", 16'(acc), 16'(g7ci_pkg::FIFO_DEPTH));
    chk("ready full", 16'(dm_rx_ready_o), 16'h0000);
    for (int n = 0; n < 4000 && !(line_tx_pos_o | line_tx_neg_o); n++) @(negedge clk_sys_i);
    repeat (244) @(negedge clk_sys_i);
    for (int b = 0; b < 9; b++) begin
      chk("mark", 16'(line_tx_pos_o ^ line_tx_neg_o), 16'h0001);
      if (b > 0) viol += int'(line_tx_pos_o == prev);
      prev = line_tx_pos_o;
      repeat (1952) @(negedge clk_sys_i);
    end
    chk("violations", 16'(viol), 16'(oct));
    $display("internal timing test done");
  endtask
  task automatic test_remote;
    int acc;
    int c;
    logic [8:0] d;
    start(2'h2, 1'b0);
    peer_run = 1'b1;
    acc = 0;
    dm_rx_valid_i = 1'b1;
    repeat (12) begin
      acc += int'(dm_rx_ready_o);
      @(negedge clk_sys_i);
    end
    dm_rx_valid_i = 1'b0;
    chk("discard ready", 16'(acc), 16'h000c);
    count_moves(1200, c, d);
    chk("echo moves", 16'(c > 0), 16'h0001);
    chk("decoder feeds", 16'(d), 16'h01a5);
    $display("remote loopback test done");
  endtask
  task automatic test_dual;
    int c;
    logic [8:0] d;
    start(2'h3, 1'b0);
    peer_run = 1'b1;
    dm_rx_data_i = 8'h3c;
    dm_rx_valid_i = 1'b1;
    @(negedge clk_sys_i);
    dm_rx_valid_i = 1'b0;
    for (int n = 0; n < 10 && dm_tx_valid_o !== 1'b1; n++) @(negedge clk_sys_i);
    chk("dual data", 16'({dm_tx_valid_o, dm_tx_data_o}), 16'h013c);
    count_moves(700, c, d);
    chk("dual line moves", 16'(c > 0), 16'h0001);
    chk("dual no leak", 16'(d), 16'h0000);
    $display("dual loopback test done");
  endtask
  task automatic test_loop;
    int c;
    logic [8:0] d;
    start(2'h0, 1'b1);
    peer_run = 1'b1;
    count_moves(700, c, d);
    chk("loop moves", 16'(c > 0), 16'h0001);
    chk("loop octet", 16'(d), 16'h01a5);
    peer_run = 1'b0;
    repeat (30) @(negedge clk_sys_i);
    count_moves(700, c, d);
    chk("loop still", 16'(c), 16'h0000);
    $display("loop timing test done");
  endtask
  initial begin
    {reset_n_i, octet_timing_switch_i, timing_mode_switch_a_i, timing_mode_switch_b_i} = 4'h0;
    {dm_rx_valid_i, dm_rx_data_i, peer_run} = 10'h000;
    miscompares = 0;
    checked = 0;
    test_internal(1'b1);
    test_internal(1'b0);
    test_remote();
    test_dual();
    test_loop();
    give_verdict();
  end
  // expected run is about 40000 cycles
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    miscompares++;
    give_verdict();
  end
endmodule
